// *** bench/master_model.sv ***
// Behavioural bus master that streams output image bytes to the node
`timescale 1ns/1ps
module master_model (
  input  wire logic       clk,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_byte,
  output logic            out_last
);
  // Nothing offered until the first image
  initial begin
    out_valid = 1'b0;
    out_byte  = 8'h00;
    out_last  = 1'b0;
  end
  // Sends n bytes base+k in slot order; call just after a rising edge
  task automatic send(input int n, input logic [7:0] base);
    int k;
    k = 0;
    while (k < n) begin
      out_valid <= 1'b1;
      out_byte  <= base + 8'(k); // Byte k fills slot k
      out_last  <= (k == n - 1);
      @(posedge clk);
      if (out_ready) begin
        k++;
        // Random gaps so the queue sees a ragged stream
        if ($urandom_range(3) == 0) begin
          out_valid <= 1'b0;
          out_byte  <= ~out_byte; // Released bus shows no stale byte
          @(posedge clk);
        end
      end
    end
    out_valid <= 1'b0;
    out_last  <= 1'b0;
    out_byte  <= ~out_byte;
  endtask
endmodule // master_model

// *** bench/test_io_image_ctrl.sv ***
// Self-checking bench for the I/O image control block
`timescale 1ns/1ps
module test_io_image_ctrl;
  import io_image_pkg::*;
  logic         clk, sys_rst, cmd_freeze, cmd_sync, cmd_unfreeze;
  logic         cmd_clear, master_stop, link_lost, resp_mon_en;
  logic [7:0]   node_ident_0, node_ident_1, node_ident_2, node_status;
  logic [5:0]   mod_in_bytes, mod_out_bytes, in_rd_idx;
  logic [511:0] mod_inputs, phys_outputs, snap;
  logic [15:0]  diag_table_in, diag_table_out;
  logic         out_valid, out_ready, out_last, frozen, synced;
  logic [7:0]   out_byte, in_rd_byte, max_data_len;
  logic [6:0]   in_len, out_len, e7;
  logic [63:0]  img;
  int           fails, compares, cycles, r;
  // Identifier table: none, status bits, diag interface
  logic [23:0]  ids [3] = '{{ID_NONE, 8'h00, 8'h00},
    {ID_STATUS_0, ID_STATUS_1, 8'h00}, {ID_DIAG_0, ID_DIAG_1, ID_DIAG_2}};
  logic [6:0]   nin [3] = '{7'h00, 7'h02, 7'h02};
  logic [6:0]   nout [3] = '{7'h00, 7'h00, 7'h02};

  io_image_ctrl io_image_ctrl_i (.*);
  master_model master_model_i (.clk(clk), .out_valid(out_valid),
    .out_ready(out_ready), .out_byte(out_byte), .out_last(out_last));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, well above the length of the sequence
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Compare and report; reads land before this edge's updates
  task automatic chk(input string nm, input logic [511:0] e,
                     input logic [511:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // One-cycle pulse: bits freeze, sync, unfreeze, clear
  task automatic cmd(input logic [3:0] c);
    {cmd_clear, cmd_unfreeze, cmd_sync, cmd_freeze} <= c;
    step(1);
    {cmd_clear, cmd_unfreeze, cmd_sync, cmd_freeze} <= 4'h0;
    step(1);
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    in_rd_idx <= i;
    step(1);
    chk("in_rd_byte", 512'(e), 512'(in_rd_byte));
  endtask
  // Send an image and wait out the three-edge apply latency
  task automatic image(input logic [7:0] b);
    master_model_i.send(8, b);
    step(4);
  endtask
  function automatic logic [63:0] exp_img(input logic [7:0] b);
    for (int k = 0; k < 8; k++) exp_img[k*8 +: 8] = b + 8'(k);
  endfunction
  task automatic conclude();
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h01faa4f1));
    {cmd_freeze, cmd_sync, cmd_unfreeze, cmd_clear} = 4'h0;
    {master_stop, link_lost, resp_mon_en} = 3'h0;
    {node_ident_0, node_ident_1, node_ident_2} = 24'h000000;
    mod_in_bytes = 6'h08;
    mod_out_bytes = 6'h08;
    mod_inputs = {16{$urandom()}};
    node_status = 8'(($urandom()));
    diag_table_in = 16'(($urandom()));
    in_rd_idx = 6'h00;
    {fails, compares, cycles} = 0;
    sys_rst = 1'b1;
    step(5);
    sys_rst <= 1'b0;
    step(1);
    chk("phys_outputs", 512'h0, phys_outputs);
    chk("max_data_len", 512'h80, 512'(max_data_len));
    // Every identifier mode's lengths; node bytes in status mode
    for (int m = 0; m < 3; m++) begin
      {node_ident_0, node_ident_1, node_ident_2} <= ids[m];
      step(2);
      e7 = 7'(mod_in_bytes) + nin[m];
      chk("in_len", 512'(e7), 512'(in_len));
      e7 = 7'(mod_out_bytes) + nout[m];
      chk("out_len", 512'(e7), 512'(out_len));
      if (m == 1) begin
        rd(6'h00, node_status);
        rd(6'h01, 8'h00);
        r = $urandom_range(7);
        rd(6'(r + 2), mod_inputs[r*8 +: 8]);
      end
    end
    {node_ident_0, node_ident_1, node_ident_2} <= 24'h000000;
    step(1);
    rd(6'h03, mod_inputs[31:24]);
    // Idle images reach outputs directly
    repeat (3) begin
      img = exp_img(8'($urandom()));
      image(img[7:0]);
      chk("phys_outputs", 512'(img), phys_outputs);
    end
    // Freeze, refreeze, unfreeze against changing live inputs
    repeat (2) begin
      snap = mod_inputs;
      cmd(4'h1);
      chk("frozen", 512'h1, 512'(frozen));
      mod_inputs <= {16{$urandom()}};
      r = $urandom_range(7);
      rd(6'(r), snap[r*8 +: 8]);
    end
    cmd(4'h4);
    chk("frozen", 512'h0, 512'(frozen));
    rd(6'h05, mod_inputs[47:40]);
    // Sync holds outputs; a second sync applies the stored image
    cmd(4'h2);
    chk("synced", 512'h1, 512'(synced));
    image(8'hA0);
    chk("phys_outputs", 512'(img), phys_outputs);
    cmd(4'h2);
    img = exp_img(8'hA0);
    chk("phys_outputs", 512'(img), phys_outputs);
    cmd(4'h4);
    image(8'hC3);
    img = exp_img(8'hC3);
    chk("phys_outputs", 512'(img), phys_outputs);
    // Lost link under monitoring drops freeze only
    cmd(4'h1);
    cmd(4'h2);
    {resp_mon_en, link_lost} <= 2'h3;
    step(3);
    chk("frozen", 512'h0, 512'(frozen));
    chk("synced", 512'h1, 512'(synced));
    link_lost <= 1'b0;
    cmd(4'h1);
    master_stop <= 1'b1;
    step(1);
    master_stop <= 1'b0;
    step(2);
    chk("modes", 512'h0, 512'({frozen, synced}));
    // Clear drives every output inactive
    image(8'h5A);
    cmd(4'h8);
    chk("phys_outputs", 512'h0, phys_outputs);
    // Diag interface: first two bytes each way belong to the node
    {node_ident_0, node_ident_1, node_ident_2} <= ids[2];
    step(2);
    rd(6'h01, diag_table_in[15:8]);
    rd(6'h02, mod_inputs[7:0]);
    image(8'h30);
    chk("diag_table_out", 512'h3130, 512'(diag_table_out));
    img = exp_img(8'h32);
    chk("phys_outputs", 512'(img[47:0]), phys_outputs);
    cmd(4'h8);
    chk("diag_table_out", 512'h0, 512'(diag_table_out));
    chk("phys_outputs", 512'h0, phys_outputs);
    conclude();
  end
endmodule // test_io_image_ctrl

// *** design/byte_fifo.sv ***
`timescale 1ns/1ps
// Small synchronous FIFO with valid/ready on both sides
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             flush
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];    // Storage
  logic [AW-1:0]    wr_ff;             // Write pointer
  logic [AW-1:0]    rd_ff;             // Read pointer
  logic [AW:0]      cnt_ff;            // Fill level
  wire              push;
  wire              pop;
  // Ready whenever a slot is free; the level is one bit wider than pointers
  assign in_ready  = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid = cnt_ff != '0;
  assign out_data  = mem_ff[rd_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // Storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
  // Pointers and level; flush drops stale bytes
  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      if (pop)  rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // byte_fifo

// *** design/io_image_ctrl.sv ***
`timescale 1ns/1ps
// Cyclic I/O image control of a fieldbus slave node
// Overview of operation
// - Freeze latches inputs; master sees snapshot
// - Repeated freeze takes a fresh snapshot
// - Sync holds outputs, ignores new images
// - Repeated sync applies latest image, holds
// - Unfreeze ends freeze and sync modes
// - Clear-data drives all outputs inactive
// - Power cycle or master stop clears modes
// - Lost link with monitoring cancels freeze only
// - Up to 64 in, 64 out bytes, 128 total
// - Addresses follow module order left to right
// - Identifier may map node status as inputs
// - 40h,00h: two status input bytes, no outputs
// - C0h,81h,81h: two in, two out bytes
module io_image_ctrl
  import io_image_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Global control commands, one-cycle pulses
  input  wire logic             cmd_freeze,
  input  wire logic             cmd_sync,
  input  wire logic             cmd_unfreeze,
  input  wire logic             cmd_clear,
  input  wire logic             master_stop,
  input  wire logic             link_lost,
  input  wire logic             resp_mon_en,
  // Node identifier bytes from configuration
  input  wire logic [7:0]       node_ident_0,
  input  wire logic [7:0]       node_ident_1,
  input  wire logic [7:0]       node_ident_2,
  input  wire logic [5:0]       mod_in_bytes,
  input  wire logic [5:0]       mod_out_bytes,
  // Live module inputs in left-to-right order
  input  wire logic [511:0]     mod_inputs,
  input  wire logic [7:0]       node_status,
  input  wire logic [15:0]      diag_table_in,
  // Output image bytes from the master
  input  wire logic             out_valid,
  output logic                  out_ready,
  input  wire logic [7:0]       out_byte,
  input  wire logic             out_last,
  // Input image read by the link side
  input  wire logic [IDX_W-1:0] in_rd_idx,
  output logic [7:0]            in_rd_byte,
  output logic [7:0]            max_data_len,
  output logic [6:0]            in_len,
  output logic [6:0]            out_len,
  // Physical outputs and node diag port
  output logic [511:0]          phys_outputs,
  output logic [15:0]           diag_table_out,
  output logic                  frozen,
  output logic                  synced
);
  node_mode_t       node_mode;          // Decoded identifier mode
  logic [1:0]       node_in_n;          // Node input bytes
  logic [1:0]       node_out_n;         // Node output bytes
  logic             freeze_ff;          // Freeze mode flag
  logic             sync_ff;            // Sync mode flag
  logic [511:0]     snap_ff;            // Frozen input snapshot
  logic [527:0]     live_img;           // Node bytes then modules
  logic [511:0]     shadow_ff;          // Assembled output image
  logic [511:0]     recv_ff;            // Last complete image
  logic             recv_new_ff;        // Complete image pending
  logic [IDX_W-1:0] wr_idx_ff;          // Assembly byte index
  logic             f_valid;            // FIFO output valid
  logic [7:0]       f_byte;             // FIFO output byte
  logic             f_last;             // Last marker
  logic [8:0]       f_word;
  wire              mode_reset;
  wire              f_take;
  wire              img_done;
  wire              apply_img;

  // Incoming bytes are buffered so the link side can be stalled
  // The drain side never stalls: one byte per cycle into the shadow
  // Extra bit carries the end-of-image marker alongside each byte
  byte_fifo #(.WIDTH(FIFO_W + 1), .DEPTH(FIFO_D)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (out_valid),
    .in_ready  (out_ready),
    .in_data   ({out_last, out_byte}),
    .out_valid (f_valid),
    .out_ready (1'b1),
    .out_data  (f_word),
    .flush     (mode_reset)
  );
  assign f_byte = f_word[7:0];
  assign f_last = f_word[8];
  assign f_take = f_valid;

  // Identifier decode; anything else maps the node to nothing
  // Unknown identifiers fall back to no space rather than a guess
  assign node_mode = (node_ident_0 == ID_STATUS_0 &&
                      node_ident_1 == ID_STATUS_1) ? NODE_STATUS :
                     (node_ident_0 == ID_DIAG_0 && node_ident_1 == ID_DIAG_1
                      && node_ident_2 == ID_DIAG_2) ? NODE_DIAG :
                     NODE_NONE;
  assign node_in_n  = (node_mode == NODE_STATUS) ? NODE_IN_STATUS :
                      (node_mode == NODE_DIAG) ? NODE_IN_DIAG : 2'h0;
  assign node_out_n = (node_mode == NODE_DIAG) ? NODE_OUT_DIAG : 2'h0;
  assign in_len  = 7'(mod_in_bytes) + 7'(node_in_n);
  assign out_len = 7'(mod_out_bytes) + 7'(node_out_n);
  assign max_data_len = DATA_LEN_MAX;

  // Node bytes sit first, modules follow in physical order
  // All module bytes are kept in the 66-byte image; reads and the snapshot reach only its low 64 bytes
  assign live_img = (node_mode == NODE_STATUS) ?
                      {mod_inputs, 8'h00, node_status} :
                    (node_mode == NODE_DIAG) ?
                      {mod_inputs, diag_table_in} :
                      {16'h0000, mod_inputs};

  // Mode exit events: reset, master stop
  // A stop also flushes half-received images so none applies later
  assign mode_reset = master_stop;

  // Freeze flag; lost link cancels it only when monitored
  // A freeze in the same cycle as a loss wins: it is the newer order
  always_ff @(posedge clk) begin
    if (sys_rst || mode_reset) begin
      freeze_ff <= 1'b0;
    end else if (cmd_freeze) begin
      freeze_ff <= 1'b1;
    end else if (cmd_unfreeze || (link_lost && resp_mon_en)) begin
      freeze_ff <= 1'b0;
    end
  end

  // Snapshot taken on every freeze command
  // Also taken on the first freeze, so no stale data is ever shown
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      snap_ff <= '0;
    end else if (cmd_freeze) begin
      snap_ff <= live_img[511:0];
    end
  end

  // Sync flag survives link loss
  // Outputs keep their held value while the master reconnects
  always_ff @(posedge clk) begin
    if (sys_rst || mode_reset) begin
      sync_ff <= 1'b0;
    end else if (cmd_sync) begin
      sync_ff <= 1'b1;
    end else if (cmd_unfreeze) begin
      sync_ff <= 1'b0;
    end
  end

  // Reads come from snapshot while frozen, live otherwise
  // Combinational read: the link side sees the byte in the same cycle
  assign in_rd_byte = freeze_ff ? snap_ff[8*in_rd_idx +: 8]
                                : live_img[8*in_rd_idx +: 8];

  // Output image assembly, one byte per cycle from FIFO
  // Bytes past the last one of a short image keep their old value
  assign img_done = f_take & f_last;
  always_ff @(posedge clk) begin
    if (sys_rst || mode_reset) begin
      wr_idx_ff <= '0;
      shadow_ff <= '0;
    end else if (f_take) begin
      shadow_ff[8*wr_idx_ff +: 8] <= f_byte;
      wr_idx_ff <= f_last ? '0 : wr_idx_ff + 1'b1;
    end
  end

  // Latest complete image, kept even while sync holds
  // The closing byte is merged here, saving one cycle of latency
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      recv_ff     <= '0;
      recv_new_ff <= 1'b0;
    end else if (img_done) begin
      recv_ff     <= shadow_ff;
      recv_ff[8*wr_idx_ff +: 8] <= f_byte;
      recv_new_ff <= 1'b1;
    end else begin
      recv_new_ff <= 1'b0;
    end
  end

  // Apply when idle on each new image, or on a sync command while already in sync
  // In sync, a fresh image only waits in the store until the next sync
  assign apply_img = (!sync_ff && recv_new_ff) ||
                     (sync_ff && cmd_sync);

  // Physical outputs; clear-data wins over any update
  // In diag mode the first two bytes go to the node, not the outputs
  always_ff @(posedge clk) begin
    if (sys_rst || cmd_clear) begin
      phys_outputs   <= {64{OUT_RESET_VAL}};
      diag_table_out <= '0;
    end else if (apply_img) begin
      phys_outputs   <= (node_mode == NODE_DIAG) ?
                          {16'h0000, recv_ff[511:16]} : recv_ff;
      diag_table_out <= (node_mode == NODE_DIAG) ? recv_ff[15:0] : 16'h0000;
    end
  end

  assign frozen = freeze_ff;
  assign synced = sync_ff;

  // A freeze command enters freeze mode unless a master stop arrives with it
  property p_freeze_set;
    @(posedge clk) disable iff (sys_rst)
      cmd_freeze && !mode_reset |=> freeze_ff;
  endproperty
  a_freeze_set: assert property (p_freeze_set)
    else $error("freeze not entered");

  // Snapshot only moves on a freeze command
  property p_snap_hold;
    @(posedge clk) disable iff (sys_rst)
      freeze_ff && !cmd_freeze |=> $stable(snap_ff);
  endproperty
  a_snap_hold: assert property (p_snap_hold)
    else $error("snapshot changed without freeze");

  // Outputs frozen in sync unless a sync or clear arrives
  property p_sync_hold;
    @(posedge clk) disable iff (sys_rst)
      sync_ff && !cmd_sync && !cmd_clear |=> $stable(phys_outputs);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("outputs moved during sync");

  // Repeated sync hands the stored image to the outputs
  property p_sync_apply;
    @(posedge clk) disable iff (sys_rst)
      sync_ff && cmd_sync && !cmd_clear && node_mode == NODE_NONE
        |=> phys_outputs == $past(recv_ff);
  endproperty
  a_sync_apply: assert property (p_sync_apply)
    else $error("sync did not apply image");

  // Unfreeze drops both modes
  property p_unfreeze;
    @(posedge clk) disable iff (sys_rst)
      cmd_unfreeze && !cmd_freeze && !cmd_sync |=> !freeze_ff && !sync_ff;
  endproperty
  a_unfreeze: assert property (p_unfreeze)
    else $error("unfreeze left a mode on");

  // Clear-data forces every output inactive
  property p_clear;
    @(posedge clk) disable iff (sys_rst)
      cmd_clear |=> phys_outputs == '0 && diag_table_out == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not reset outputs");

  // Master stop drops both modes
  property p_stop;
    @(posedge clk) disable iff (sys_rst)
      master_stop |=> !freeze_ff && !sync_ff;
  endproperty
  a_stop: assert property (p_stop)
    else $error("modes survived master stop");

  // Monitored link loss drops freeze but keeps sync
  property p_link_lost;
    @(posedge clk) disable iff (sys_rst)
      link_lost && resp_mon_en && !cmd_freeze && !cmd_unfreeze
        && !mode_reset && sync_ff |=> !freeze_ff && sync_ff;
  endproperty
  a_link_lost: assert property (p_link_lost)
    else $error("link loss mode handling wrong");

  // Without sync a complete image reaches the outputs
  property p_idle_apply;
    @(posedge clk) disable iff (sys_rst)
      img_done && !sync_ff && !cmd_sync && !cmd_clear && !mode_reset
        ##1 !sync_ff && !cmd_clear |=> $changed(phys_outputs) ||
        phys_outputs == $past(recv_ff) || node_mode != NODE_NONE;
  endproperty
  a_idle_apply: assert property (p_idle_apply)
    else $error("image not applied while idle");

  // Reported total length is fixed
  property p_max_len;
    @(posedge clk) disable iff (sys_rst)
      max_data_len == 8'h80;
  endproperty
  a_max_len: assert property (p_max_len)
    else $error("wrong total data length");

  // No node space without a known identifier
  property p_none_len;
    @(posedge clk) disable iff (sys_rst)
      node_mode == NODE_NONE |-> in_len == 7'(mod_in_bytes)
        && out_len == 7'(mod_out_bytes);
  endproperty
  a_none_len: assert property (p_none_len)
    else $error("node took space without identifier");

  // Status mode puts the status byte first
  property p_status_byte;
    @(posedge clk) disable iff (sys_rst)
      node_mode == NODE_STATUS && !freeze_ff && in_rd_idx == '0
        |-> in_rd_byte == node_status;
  endproperty
  a_status_byte: assert property (p_status_byte)
    else $error("status byte not at image start");

  // Diag mode routes the first two image bytes to the node
  property p_diag_out;
    @(posedge clk) disable iff (sys_rst)
      node_mode == NODE_DIAG && apply_img && !cmd_clear
        |=> diag_table_out == $past(recv_ff[15:0]);
  endproperty
  a_diag_out: assert property (p_diag_out)
    else $error("diag word not taken from image");

  // Each freeze captures the image as it stood
  property p_snap_take;
    @(posedge clk) disable iff (sys_rst)
      cmd_freeze |=> snap_ff == $past(live_img[511:0]);
  endproperty
  a_snap_take: assert property (p_snap_take)
    else $error("snapshot not refreshed");

  // Unfrozen reads follow the live image
  property p_live_read;
    @(posedge clk) disable iff (sys_rst)
      !freeze_ff |-> in_rd_byte == live_img[8*in_rd_idx +: 8];
  endproperty
  a_live_read: assert property (p_live_read)
    else $error("live read wrong");

  // Without node bytes, module bytes start at index zero
  property p_mod_order;
    @(posedge clk) disable iff (sys_rst)
      node_mode == NODE_NONE && !freeze_ff
        |-> in_rd_byte == mod_inputs[8*in_rd_idx +: 8];
  endproperty
  a_mod_order: assert property (p_mod_order)
    else $error("module byte order wrong");

  // A stop throws away any queued image bytes
  property p_stop_flush;
    @(posedge clk) disable iff (sys_rst)
      master_stop |=> !f_valid;
  endproperty
  a_stop_flush: assert property (p_stop_flush)
    else $error("queue kept bytes after stop");
endmodule // io_image_ctrl

// *** design/io_image_pkg.sv ***
// Constants and types shared by the fieldbus slave I/O image block
package io_image_pkg;
  localparam int IN_BYTES_MAX   = 64;       // Largest input image
  localparam int OUT_BYTES_MAX  = 64;       // Largest output image
  localparam logic [7:0] DATA_LEN_MAX = 8'h80; // Reported total length
  localparam int IDX_W          = 6;        // Byte index width
  localparam int FIFO_W         = 8;        // Output byte FIFO width
  localparam int FIFO_D         = 8;        // Output byte FIFO depth
  localparam logic [7:0] ID_NONE      = 8'h00; // Node takes no space
  localparam logic [7:0] ID_STATUS_0  = 8'h40; // Status bit mode, byte 0
  localparam logic [7:0] ID_STATUS_1  = 8'h00; // Status bit mode, byte 1
  localparam logic [7:0] ID_DIAG_0    = 8'hC0; // Diag interface, byte 0
  localparam logic [7:0] ID_DIAG_1    = 8'h81; // Diag interface, byte 1
  localparam logic [7:0] ID_DIAG_2    = 8'h81; // Diag interface, byte 2
  localparam logic [1:0] NODE_IN_STATUS = 2'h2; // Status mode input bytes
  localparam logic [1:0] NODE_IN_DIAG   = 2'h2; // Diag mode input bytes
  localparam logic [1:0] NODE_OUT_DIAG  = 2'h2; // Diag mode output bytes
  localparam logic [7:0] OUT_RESET_VAL  = 8'h00; // Inactive output level
  // Node self-mapping modes chosen by identifier
  typedef enum logic [1:0] {NODE_NONE, NODE_STATUS, NODE_DIAG} node_mode_t;
endpackage
